// [hot_alert_pkg.sv]
// shared constants and carrier types for the hot alert status and control block
package hot_alert_pkg;

  // register offsets (byte addresses on the host serial register port)
  localparam logic [7:0] PROFILE_FLAGS_ADDR = 8'h22;
  localparam logic [7:0] PULSE_CTRL_ADDR = 8'h23;

  // profile flag byte field positions
  localparam int VOLT_LIMIT_BIT = 7;
  localparam int COMPARATOR_BIT = 6;
  localparam int CRIT_CURRENT_BIT = 5;
  localparam int NOM_CURRENT_BIT = 4;
  localparam int DISCHARGE_BIT = 3;
  localparam int SYS_VOLTAGE_BIT = 2;
  localparam int BAT_REMOVAL_BIT = 1;
  localparam int ADPT_REMOVAL_BIT = 0;
  localparam logic [7:0] READ_CLEAR_MASK = 8'h7f;

  // pulse control byte field positions
  localparam int CTRL_FIXED_ONE_BIT = 7;
  localparam int STRETCH_EN_BIT = 6;
  localparam int WIDTH_HI_BIT = 5;
  localparam int WIDTH_LO_BIT = 4;
  localparam int PULSE_CLEAR_BIT = 3;
  localparam int THERMAL_BIT = 2;
  localparam int ASSIST_FAIL_BIT = 1;
  localparam int ASSIST_EXIT_BIT = 0;

  // reset values
  localparam logic [7:0] PROFILE_FLAGS_RESET = 8'h00;
  localparam logic STRETCH_EN_RESET = 1'b0;
  localparam logic [1:0] WIDTH_RESET = 2'h3;
  localparam logic PULSE_CLEAR_RESET = 1'b1;

  // minimum pulse width codes
  localparam logic [1:0] WIDTH_100US = 2'h0;
  localparam logic [1:0] WIDTH_1MS = 2'h1;
  localparam logic [1:0] WIDTH_5MS = 2'h2;
  localparam logic [1:0] WIDTH_10MS = 2'h3;

  // timing
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int PULSE_100US_NS = 100000;
  localparam int PULSE_1MS_NS = 1000000;
  localparam int PULSE_5MS_NS = 5000000;
  localparam int PULSE_10MS_NS = 10000000;
  // least times: round up to whole cycles
  localparam int PULSE_100US_CYCLES = (PULSE_100US_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PULSE_1MS_CYCLES = (PULSE_1MS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PULSE_5MS_CYCLES = (PULSE_5MS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PULSE_10MS_CYCLES = (PULSE_10MS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ASSIST_FAIL_TRIES = 7;

  // condition inputs from the analog and power-stage side
  typedef struct packed {
    logic volt_limit_trig;
    logic comparator_trig;
    logic crit_current_trig;
    logic nom_current_trig;
    logic discharge_trig;
    logic sys_voltage_trig;
    logic bat_removal_trig;
    logic adpt_removal_trig;
    logic input_voltage_profile_enable;
    logic thermal_shutdown;
    logic voltage_assist_mode;
    logic assist_load_fail;
    logic assist_load_ok;
    logic assist_host_disable;
    logic input_overvoltage;
    logic input_overcurrent;
    logic system_overvoltage;
    logic battery_overvoltage;
    logic system_undervoltage;
  } alert_events_t;

  typedef enum logic [2:0] {
    PULSE_IDLE = 3'b001,
    PULSE_TIMED = 3'b010,
    PULSE_HELD = 3'b100
  } pulse_state_t;

endpackage

// [hot_alert_status_control.sv]
// hot alert pin status flags, pulse timer and register byte port
//
// Contract
// - stretch enabled: pin stays low after trigger until clear bit written 0
// - unstretched pulse lasts at least selected width: 100us, 1ms, 5ms, 10ms
// - host writes clear bit 0 to end stretched pulse; bit idles at 1
// - read-only thermal shutdown flag, zero after reset
// - seven consecutive failed loads in voltage assist set the fail flag
// - fail flag forces assist off, latched until host writes it 0
// - exit flag sets when assist ends by host disable or any fault
// - exit flag holds pin low until host writes it 0
// - enabled input voltage profile trigger sets flag, holds pin low
// - comparator profile flag latches until host reads the register
// - critical current flag latches until host read, resets to zero
// - nominal current flag latches until host reads the register
// - discharge current flag latches until host reads the register
// - system voltage flag latches until host reads the register
// - battery removal flag latches until host reads the register
// - adapter removal flag latches until host reads the register
`timescale 1ns/1ps

module hot_alert_status_control #(
  parameter int CYCLES_100US = hot_alert_pkg::PULSE_100US_CYCLES,
  parameter int CYCLES_1MS = hot_alert_pkg::PULSE_1MS_CYCLES,
  parameter int CYCLES_5MS = hot_alert_pkg::PULSE_5MS_CYCLES,
  parameter int CYCLES_10MS = hot_alert_pkg::PULSE_10MS_CYCLES,
  parameter int COUNT_WIDTH = 18
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire hot_alert_pkg::alert_events_t events,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic hot_alert_pin_out,
  output logic hot_alert_pin_oe,
  output logic assist_latched_off
);

  // a count wider than the counter would wrap and cut pulses short
  if (COUNT_WIDTH > 31 || CYCLES_100US < 1 || CYCLES_1MS < 1 || CYCLES_5MS < 1
      || CYCLES_10MS < 1 || CYCLES_10MS >= (1 << COUNT_WIDTH)
      || CYCLES_5MS >= (1 << COUNT_WIDTH) || CYCLES_1MS >= (1 << COUNT_WIDTH)
      || CYCLES_100US >= (1 << COUNT_WIDTH))
  begin
    $error("pulse width counts do not fit the counter");
  end

  localparam logic [COUNT_WIDTH-1:0] LOAD_100US = COUNT_WIDTH'(CYCLES_100US);
  localparam logic [COUNT_WIDTH-1:0] LOAD_1MS = COUNT_WIDTH'(CYCLES_1MS);
  localparam logic [COUNT_WIDTH-1:0] LOAD_5MS = COUNT_WIDTH'(CYCLES_5MS);
  localparam logic [COUNT_WIDTH-1:0] LOAD_10MS = COUNT_WIDTH'(CYCLES_10MS);
  localparam logic [2:0] FAIL_LIMIT = 3'(hot_alert_pkg::ASSIST_FAIL_TRIES);

  // register state
  logic [7:0] profile_flags_reg, profile_flags_next;
  logic stretch_en_reg, stretch_en_next;
  logic [1:0] width_reg, width_next;
  logic pulse_clear_reg, pulse_clear_next;
  logic thermal_reg, thermal_next;
  logic assist_fail_reg, assist_fail_next;
  logic assist_exit_reg, assist_exit_next;
  logic assist_prev_reg, assist_prev_next;
  logic [2:0] fail_count_reg, fail_count_next;
  logic [7:0] rdata_reg, rdata_next;

  // pulse state
  hot_alert_pkg::pulse_state_t pulse_state_reg, pulse_state_next;
  logic [COUNT_WIDTH-1:0] count_reg, count_next;
  logic pin_oe_reg, pin_oe_next;
  logic latched_off_reg, latched_off_next;

  logic wr_flags, wr_ctrl, rd_flags;
  logic [7:0] profile_set;
  logic exit_cause, trigger;
  logic [7:0] ctrl_view;
  logic [COUNT_WIDTH-1:0] width_load;

  assign wr_flags = reg_write && reg_addr == hot_alert_pkg::PROFILE_FLAGS_ADDR;
  assign wr_ctrl = reg_write && reg_addr == hot_alert_pkg::PULSE_CTRL_ADDR;
  assign rd_flags = reg_read && reg_addr == hot_alert_pkg::PROFILE_FLAGS_ADDR;

  // reserved top bit of the control byte always reads one
  assign ctrl_view = {1'b1, stretch_en_reg, width_reg, pulse_clear_reg,
                      thermal_reg, assist_fail_reg, assist_exit_reg};

  always_comb
  begin
    profile_set = '0;
    profile_set[hot_alert_pkg::VOLT_LIMIT_BIT] =
      events.volt_limit_trig && events.input_voltage_profile_enable;
    profile_set[hot_alert_pkg::COMPARATOR_BIT] = events.comparator_trig;
    profile_set[hot_alert_pkg::CRIT_CURRENT_BIT] = events.crit_current_trig;
    profile_set[hot_alert_pkg::NOM_CURRENT_BIT] = events.nom_current_trig;
    profile_set[hot_alert_pkg::DISCHARGE_BIT] = events.discharge_trig;
    profile_set[hot_alert_pkg::SYS_VOLTAGE_BIT] = events.sys_voltage_trig;
    profile_set[hot_alert_pkg::BAT_REMOVAL_BIT] = events.bat_removal_trig;
    profile_set[hot_alert_pkg::ADPT_REMOVAL_BIT] = events.adpt_removal_trig;
  end

  assign exit_cause = events.assist_host_disable || events.input_overvoltage
                      || events.input_overcurrent || events.system_overvoltage
                      || events.battery_overvoltage || events.system_undervoltage;

  // register file and status flags
  always_comb
  begin
    profile_flags_next = profile_flags_reg;
    stretch_en_next = stretch_en_reg;
    width_next = width_reg;
    pulse_clear_next = pulse_clear_reg;
    assist_fail_next = assist_fail_reg;
    assist_exit_next = assist_exit_reg;
    fail_count_next = fail_count_reg;
    rdata_next = rdata_reg;
    thermal_next = events.thermal_shutdown;
    assist_prev_next = events.voltage_assist_mode && !latched_off_reg;
    if (reg_read)
    begin
      if (reg_addr == hot_alert_pkg::PROFILE_FLAGS_ADDR)
        rdata_next = profile_flags_reg;
      else if (reg_addr == hot_alert_pkg::PULSE_CTRL_ADDR)
        rdata_next = ctrl_view;
      else
        rdata_next = 8'h00;
    end
    // read clear first, set applied after
    if (rd_flags)
      profile_flags_next = profile_flags_next & ~hot_alert_pkg::READ_CLEAR_MASK;
    if (wr_flags && !reg_wdata[hot_alert_pkg::VOLT_LIMIT_BIT])
      profile_flags_next[hot_alert_pkg::VOLT_LIMIT_BIT] = 1'b0;
    profile_flags_next = profile_flags_next | profile_set;
    if (wr_ctrl)
    begin
      stretch_en_next = reg_wdata[hot_alert_pkg::STRETCH_EN_BIT];
      width_next = reg_wdata[hot_alert_pkg::WIDTH_HI_BIT:hot_alert_pkg::WIDTH_LO_BIT];
      pulse_clear_next = reg_wdata[hot_alert_pkg::PULSE_CLEAR_BIT];
      // host write of zero releases latch
      if (!reg_wdata[hot_alert_pkg::ASSIST_FAIL_BIT])
        assist_fail_next = 1'b0;
      // host write of zero releases exit
      if (!reg_wdata[hot_alert_pkg::ASSIST_EXIT_BIT])
        assist_exit_next = 1'b0;
    end
    else if (!pulse_clear_reg)
    begin
      pulse_clear_next = 1'b1;
    end
    if (!assist_prev_reg || events.assist_load_ok)
      fail_count_next = 3'h0;
    else if (events.assist_load_fail)
    begin
      if (fail_count_reg == FAIL_LIMIT - 3'h1)
      begin
        fail_count_next = 3'h0;
        assist_fail_next = 1'b1;
      end
      else
        fail_count_next = fail_count_reg + 3'h1;
    end
    // assist ended by disable or fault
    if (assist_prev_reg && exit_cause)
      assist_exit_next = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      profile_flags_reg <= hot_alert_pkg::PROFILE_FLAGS_RESET;
      stretch_en_reg <= hot_alert_pkg::STRETCH_EN_RESET;
      width_reg <= hot_alert_pkg::WIDTH_RESET;
      pulse_clear_reg <= hot_alert_pkg::PULSE_CLEAR_RESET;
      thermal_reg <= 1'b0;
      assist_fail_reg <= 1'b0;
      assist_exit_reg <= 1'b0;
      assist_prev_reg <= 1'b0;
      fail_count_reg <= 3'h0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      profile_flags_reg <= profile_flags_next;
      stretch_en_reg <= stretch_en_next;
      width_reg <= width_next;
      pulse_clear_reg <= pulse_clear_next;
      thermal_reg <= thermal_next;
      assist_fail_reg <= assist_fail_next;
      assist_exit_reg <= assist_exit_next;
      assist_prev_reg <= assist_prev_next;
      fail_count_reg <= fail_count_next;
      rdata_reg <= rdata_next;
    end
  end

  // a trigger is any profile set or a fresh assist exit
  assign trigger = (|profile_set) || (assist_exit_next && !assist_exit_reg);

  always_comb
  begin
    unique case (width_reg)
      hot_alert_pkg::WIDTH_100US: width_load = LOAD_100US;
      hot_alert_pkg::WIDTH_1MS: width_load = LOAD_1MS;
      hot_alert_pkg::WIDTH_5MS: width_load = LOAD_5MS;
      hot_alert_pkg::WIDTH_10MS: width_load = LOAD_10MS;
    endcase
  end

  // pulse generator; a new trigger restarts the width, so pulses merge rather than split
  always_comb
  begin
    pulse_state_next = pulse_state_reg;
    count_next = count_reg;
    unique case (pulse_state_reg)
      hot_alert_pkg::PULSE_IDLE:
      begin
        count_next = '0;
      end
      hot_alert_pkg::PULSE_TIMED:
      begin
        count_next = count_reg - COUNT_WIDTH'(1);
        if (count_reg == COUNT_WIDTH'(1))
          pulse_state_next = hot_alert_pkg::PULSE_IDLE;
      end
      hot_alert_pkg::PULSE_HELD:
      begin
        if (wr_ctrl && !reg_wdata[hot_alert_pkg::PULSE_CLEAR_BIT])
          pulse_state_next = hot_alert_pkg::PULSE_IDLE;
      end
      default:
      begin
        pulse_state_next = hot_alert_pkg::PULSE_IDLE;
        count_next = '0;
      end
    endcase
    // trigger wins over a same-cycle clear only with stretch enabled; with stretch off the held pulse still ends
    if (trigger && stretch_en_reg)
      pulse_state_next = hot_alert_pkg::PULSE_HELD;
    else if (trigger && pulse_state_reg != hot_alert_pkg::PULSE_HELD)
    begin
      pulse_state_next = hot_alert_pkg::PULSE_TIMED;
      count_next = width_load;
    end
    // pin low for pulse or holding flag
    pin_oe_next = pulse_state_next != hot_alert_pkg::PULSE_IDLE || assist_exit_next
                  || profile_flags_next[hot_alert_pkg::VOLT_LIMIT_BIT];
    latched_off_next = assist_fail_next;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pulse_state_reg <= hot_alert_pkg::PULSE_IDLE;
      count_reg <= '0;
      pin_oe_reg <= 1'b0;
      latched_off_reg <= 1'b0;
    end
    else
    begin
      pulse_state_reg <= pulse_state_next;
      count_reg <= count_next;
      pin_oe_reg <= pin_oe_next;
      latched_off_reg <= latched_off_next;
    end
  end

  // open-drain pin only ever pulls low
  assign hot_alert_pin_out = 1'b0;
  assign hot_alert_pin_oe = pin_oe_reg;
  assign reg_rdata = rdata_reg;
  assign assist_latched_off = latched_off_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence timed_start_s;
    pulse_state_reg == hot_alert_pkg::PULSE_TIMED && $past(trigger);
  endsequence

  sequence held_clear_s;
    pulse_state_reg == hot_alert_pkg::PULSE_HELD && wr_ctrl
      && !reg_wdata[hot_alert_pkg::PULSE_CLEAR_BIT] && !trigger;
  endsequence

  stretch_hold_a: assert property (pulse_state_reg == hot_alert_pkg::PULSE_HELD
    && !(wr_ctrl && !reg_wdata[hot_alert_pkg::PULSE_CLEAR_BIT]) |=> pin_oe_reg)
    else $error("held pulse released without clear");

  // width sampled at the trigger edge, since a same-cycle write may change it
  min_width_a: assert property (timed_start_s
    ##0 ($past(width_reg) == hot_alert_pkg::WIDTH_100US) |-> count_reg == LOAD_100US)
    else $error("timed pulse loaded wrong width");

  // a back-to-back control write may legally keep the clear bit at zero
  pulse_clear_a: assert property (held_clear_s
    |=> pulse_state_reg == hot_alert_pkg::PULSE_IDLE ##0 pulse_clear_reg == 1'b0
    ##1 (pulse_clear_reg || $past(wr_ctrl)))
    else $error("clear write did not end held pulse");

  thermal_flag_a: assert property (thermal_reg == $past(events.thermal_shutdown))
    else $error("thermal flag does not follow shutdown");

  fail_count_a: assert property ($rose(assist_fail_reg)
    |-> $past(fail_count_reg) == FAIL_LIMIT - 3'h1)
    else $error("fail flag set at wrong attempt count");

  // the host may clear the flag at any edge, so check the latch and the mode drop
  latch_off_a: assert property (assist_fail_reg
    |-> latched_off_reg ##1 !assist_prev_reg)
    else $error("fail flag did not latch assist off");

  exit_set_a: assert property (assist_prev_reg && exit_cause |=> assist_exit_reg)
    else $error("assist exit not flagged");

  exit_pin_a: assert property (assist_exit_reg |-> pin_oe_reg)
    else $error("exit flag set but pin released");

  volt_gate_a: assert property (events.volt_limit_trig
    && events.input_voltage_profile_enable
    |=> profile_flags_reg[hot_alert_pkg::VOLT_LIMIT_BIT] ##0 pin_oe_reg)
    else $error("voltage profile trigger not latched");

  read_keep_a: assert property (rd_flags && events.crit_current_trig
    |=> profile_flags_reg[hot_alert_pkg::CRIT_CURRENT_BIT])
    else $error("trigger lost during read clear");

  read_clear_a: assert property (rd_flags && !(|profile_set[6:0])
    |=> profile_flags_reg[6:0] == 7'h00)
    else $error("profile flags not cleared by read");

  pulse_pin_a: assert property (pulse_state_reg != hot_alert_pkg::PULSE_IDLE
    |-> pin_oe_reg)
    else $error("pulse active but pin released");

endmodule

// [host_model.sv]
// host side of the register byte port: strobed writes and completed reads
`timescale 1ns/1ps

module host_model (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic [7:0] reg_wdata,
  output logic reg_read,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read = 1'b0;
  end

  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    reg_addr = addr;
    reg_wdata = data;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    // released lines show junk so a stale value never looks like a request
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    reg_addr = addr;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    reg_addr = ~addr;
    data = reg_rdata;
  endtask
endmodule

// [hot_alert_status_control_tb.sv]
// self-checking bench for the hot alert status and control block
`timescale 1ns/1ps

module hot_alert_status_control_tb;
  localparam int widths [4] = '{4, 8, 12, 16};
  logic clock;
  logic reset_n;
  hot_alert_pkg::alert_events_t events;
  logic [7:0] reg_addr;
  logic reg_write;
  logic [7:0] reg_wdata;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic pin_out;
  logic pin_oe;
  logic latched_off;
  logic [7:0] rd;
  int num_errors;
  int comparisons;

  hot_alert_status_control #(.CYCLES_100US(4), .CYCLES_1MS(8), .CYCLES_5MS(12),
    .CYCLES_10MS(16)) DUT (.clock(clock), .reset_n(reset_n), .events(events),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .hot_alert_pin_out(pin_out),
    .hot_alert_pin_oe(pin_oe), .assist_latched_off(latched_off));

  host_model host (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check_byte(input logic [7:0] act, input logic [7:0] exp);
    comparisons++;
    if (act !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic check_bit(input logic act, input logic exp);
    check_byte({7'h00, act}, {7'h00, exp});
  endtask

  task automatic pulse(input int idx);
    @(negedge clock);
    events[idx] = 1'b1;
    @(negedge clock);
    events[idx] = 1'b0;
  endtask

  task automatic pin_after(input int n, input logic exp);
    repeat (n) @(negedge clock);
    check_bit(pin_oe, exp);
  endtask

  task automatic t_reset();
    host.read_byte(8'h22, rd);
    check_byte(rd, 8'h00);
    host.read_byte(8'h23, rd);
    check_byte(rd, 8'hb8);
    host.read_byte(8'h30, rd);
    check_byte(rd, 8'h00);
    check_bit(pin_oe, 1'b0);
    check_bit(pin_out, 1'b0);
  endtask

  // the first pass runs on the width code left by reset
  task automatic t_widths();
    int cnt;
    for (int c = 3; c >= 0; c--)
    begin
      if (c != 3)
        host.write_byte(8'h23, 8'h88 | 8'(c << 4));
      pulse(17);
      cnt = 0;
      while (pin_oe === 1'b1 && cnt < 100)
      begin
        cnt++;
        @(negedge clock);
      end
      check_byte(8'(cnt), 8'(widths[c]));
      host.read_byte(8'h22, rd);
      check_byte(rd, 8'h40);
    end
  endtask

  task automatic t_flags();
    for (int b = 0; b < 7; b++)
    begin
      pulse(11 + b);
      host.read_byte(8'h22, rd);
      check_byte(rd, 8'h01 << b);
      host.read_byte(8'h22, rd);
      check_byte(rd, 8'h00);
    end
    fork
      host.read_byte(8'h22, rd);
      pulse(16);
    join
    check_byte(rd, 8'h00);
    host.read_byte(8'h22, rd);
    check_byte(rd, 8'h20);
  endtask

  task automatic t_volt();
    pulse(18);
    host.read_byte(8'h22, rd);
    check_byte(rd, 8'h00);
    events.input_voltage_profile_enable = 1'b1;
    pulse(18);
    pin_after(40, 1'b1);
    host.read_byte(8'h22, rd);
    check_byte(rd, 8'h80);
    host.write_byte(8'h22, 8'h00);
    pin_after(2, 1'b0);
    host.read_byte(8'h22, rd);
    check_byte(rd, 8'h00);
  endtask

  task automatic t_stretch();
    host.write_byte(8'h23, 8'hc8);
    pulse(16);
    pin_after(40, 1'b1);
    host.write_byte(8'h23, 8'hc0);
    pin_after(2, 1'b0);
    host.read_byte(8'h23, rd);
    check_byte(rd, 8'hc8);
    host.write_byte(8'h23, 8'h88);
    events.thermal_shutdown = 1'b1;
    host.write_byte(8'h23, 8'h88);
    host.read_byte(8'h23, rd);
    check_byte(rd, 8'h8c);
    events.thermal_shutdown = 1'b0;
    host.read_byte(8'h23, rd);
    check_byte(rd, 8'h88);
  endtask

  task automatic t_assist();
    events.voltage_assist_mode = 1'b1;
    repeat (6) pulse(7);
    pulse(6);
    repeat (6) pulse(7);
    host.read_byte(8'h23, rd);
    check_bit(rd[1], 1'b0);
    pulse(7);
    repeat (2) @(negedge clock);
    check_bit(latched_off, 1'b1);
    host.read_byte(8'h23, rd);
    check_bit(rd[1], 1'b1);
    host.write_byte(8'h23, 8'h88);
    pin_after(20, 1'b0);
    check_bit(latched_off, 1'b0);
    host.write_byte(8'h23, 8'h88);
    for (int c = 5; c >= 0; c--)
    begin
      pulse(c);
      pin_after(30, 1'b1);
      host.read_byte(8'h23, rd);
      check_bit(rd[0], 1'b1);
      host.write_byte(8'h23, 8'h88);
      pin_after(2, 1'b0);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    num_errors = 0;
    comparisons = 0;
    events = '0;
    reset_n = 1'b0;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_widths();
    t_flags();
    t_volt();
    t_stretch();
    t_assist();
    print_verdict();
  end
endmodule
